// ### hw/scpst_pkg.sv
package scpst_pkg;
    // Register byte offsets inside the block
    localparam logic [11:0] OFF_APP_INT_RST_CTRL = 12'h00c;
    localparam logic [11:0] OFF_LOW_POWER_CTRL   = 12'h010;
    localparam logic [11:0] OFF_CORE_CONFIG_CTRL = 12'h014;
    localparam logic [11:0] OFF_FAULT_PRIO_1     = 12'h018;
    localparam logic [11:0] OFF_SVC_PRIO_2       = 12'h01c;
    localparam logic [11:0] OFF_TICK_PRIO_3      = 12'h020;
    // Write key and read-back status of the control word
    localparam logic [15:0] WRITE_KEY_VALUE      = 16'h05fa;
    localparam logic [15:0] WRITE_KEY_STATUS     = 16'hfa05;
    localparam int          SPLIT_LSB            = 8;
    localparam int          KEY_LSB              = 16;
    localparam logic [2:0]  SPLIT_RESET          = 3'h0;
    localparam logic [2:0]  SPLIT_MIN            = 3'h3;
    // Field positions of the low-power control word
    localparam int          WAKE_ANY_BIT         = 4;
    localparam int          DEEP_SLEEP_BIT       = 2;
    localparam int          SLEEP_EXIT_BIT       = 1;
    // Field positions of the core configuration word
    localparam int          STACK_ALIGN_BIT      = 9;
    localparam int          BUS_FAULT_IGN_BIT    = 8;
    localparam int          DIV_ZERO_TRAP_BIT    = 4;
    localparam int          MISALIGN_TRAP_BIT    = 3;
    localparam int          SOFT_IRQ_EN_BIT      = 1;
    localparam int          THREAD_ANY_BIT       = 0;
    // Writable bits per stored word; all else reads zero
    localparam int          NUM_REGS             = 5;
    localparam logic [NUM_REGS*32-1:0] REG_WMASK = {
        32'hf0f00000, 32'hf0000000, 32'h00f0f0f0, 32'h0000031b, 32'h00000016};
    localparam logic [NUM_REGS*32-1:0] REG_RESET = {NUM_REGS{32'h00000000}};

    // Requests from the core pipeline, one cycle pulses or levels
    typedef struct packed {
        logic       pend_enabled;
        logic       pend_disabled;
        logic       sev_exec;
        logic       wfe_exec;
        logic       sleep_req;
        logic       handler_exit;
        logic       exc_entry;
        logic       sp_bit2;
        logic       exception_return_code;
        logic       stacked_align;
        logic       ldst_bus_fault;
        logic       neg_prio_exec;
        logic       div_exec;
        logic       divisor_zero;
        logic       access_exec;
        logic       access_unaligned;
        logic       access_multi;
        logic       software_irq_trigger_register_access;
        logic       unprivileged;
        logic       return_to_thread;
        logic       other_active;
        logic [7:0] new_prio;
        logic [7:0] run_prio;
    } scpst_req_t;

    // Decisions handed back to the core, registered
    typedef struct packed {
        logic       wfe_done;
        logic       event_latched;
        logic       sleep_enter;
        logic       deep_sleep;
        logic       align_pad;
        logic       sp_restore_pad;
        logic       bus_fault_ignored;
        logic       lockup;
        logic       div_trap;
        logic       div_zero_result;
        logic       usage_fault;
        logic       software_irq_trigger_register_allowed;
        logic       thread_entry_ok;
        logic       preempt;
        logic [3:0] new_group;
        logic [3:0] new_sub;
    } scpst_resp_t;

    typedef enum logic {EV_RUN, EV_WAIT} scpst_ev_state_t;
endpackage : scpst_pkg

// ### hw/scpst_sys_ctrl.sv
// Notes on behaviour
// (RL1) Split selector sets group and subpriority bits
// (RL2) Preemption compares group priority only
// (RL3) Wake-any bit lets disabled interrupts wake
// (RL4) Pending event wakes wait or is latched
// (RL5) Send-event or external event also wakes
// (RL6) Deep-sleep bit selects sleep depth
// (RL7) Sleep-after-exit sleeps on return to thread
// (RL8) Stack alignment recorded and restored via bit9
// (RL9) Bus-fault ignore at priority -1/-2, else lockup
// (RL10) Zero divisor traps or yields zero
// (RL11) Misaligned trap bit faults unaligned accesses
// (RL12) Unaligned multiple/double accesses always fault
// (RL13) Soft-irq enable gates unprivileged trigger access
// (RL14) Thread-entry bit allows thread from any level
// (RL15) Priority fields store upper four bits only
// (RL16) Priority registers accept byte writes
// (RL17) First priority word: mem, bus, usage faults
// (RL18) Second holds supervisor call, third deferred/tick
// (RL19) Field positions 31:24 and 23:16 for these
// (RL20) Control word writes need key 0x5fa
// (RL21) Reserved bits read zero, ignore writes
module scpst_sys_ctrl
    import scpst_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  hsel,
    input  wire logic [11:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire logic                  ext_event_pin,
    input  wire scpst_pkg::scpst_req_t core_req,
    output scpst_pkg::scpst_resp_t     core_resp
);
    import scpst_pkg::*;

    // Data phase bookkeeping
    logic        dp_valid_q;             // Read or write pending in data phase
    logic        dp_write_q;             // Pending access is a write
    logic [11:0] dp_addr_q;              // Byte address of pending access
    logic [3:0]  dp_mask_q;              // Byte lanes of pending access
    logic [3:0]  lane_mask;              // Lanes decoded from size and address
    logic        addr_take;              // Address phase accepted

    // Register state
    logic [2:0]  split_q;                // Priority split selector
    logic [31:0] regs_q [NUM_REGS];      // Stored words, masked
    logic [31:0] lane_bits;              // Lane mask widened to bits
    logic        key_ok;                 // Key present and correct
    logic        ctrl_wr;                // Keyed control word write
    logic [31:0] ctrl_rd;                // Control word read value
    logic [31:0] rd_mux;                 // Read value for data phase

    // Event and wait state
    scpst_ev_state_t ev_state_q;
    scpst_ev_state_t ev_state_d;
    logic        ev_latch_q;             // Event seen while not waiting
    logic        ev_latch_d;
    logic        wfe_done_d;             // Wait completes this cycle
    logic        ext_s1_q;               // Synchroniser first stage
    logic        ext_s2_q;               // Synchroniser second stage
    logic        ext_s3_q;               // Edge history
    logic        ext_rise;               // External event edge
    logic        wake_ev;                // Any wake source this cycle

    // Decoded configuration bits
    logic        wake_any;
    logic        deep_sel;
    logic        sleep_exit;
    logic        align8;
    logic        bf_ign;
    logic        div_trap_en;
    logic        misalign_en;
    logic        soft_irq_en;
    logic        thread_any;

    // Priority split
    logic [3:0]  grp_mask;               // Group bits within [7:4]
    logic [2:0]  split_eff;              // Selector clamped to legal range
    logic [3:0]  new_grp;
    logic [3:0]  run_grp;

    scpst_resp_t resp_d;
    scpst_resp_t resp_q;

    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_take = hsel & htrans[1] & hready;

    // Byte lanes from size and low address bits (RL16)
    assign lane_mask = (hsize == 3'h0) ? (4'h1 << haddr[1:0]) :
                       (hsize == 3'h1) ? (haddr[1] ? 4'hc : 4'h3) :
                                         4'hf;

    // Capture the address phase
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q  <= 12'h000;
            dp_mask_q  <= 4'h0;
        end else begin
            dp_valid_q <= addr_take;
            dp_write_q <= hwrite;
            dp_addr_q  <= haddr;
            dp_mask_q  <= lane_mask;
        end
    end

    // Lane mask spread to bit granularity
    assign lane_bits = {{8{dp_mask_q[3]}}, {8{dp_mask_q[2]}},
                        {8{dp_mask_q[1]}}, {8{dp_mask_q[0]}}};

    // Key must come in the upper half with the same access (RL20)
    assign key_ok  = (&dp_mask_q[3:2]) &&
                     (hwdata[KEY_LSB +: 16] == WRITE_KEY_VALUE);
    assign ctrl_wr = dp_valid_q & dp_write_q & key_ok & dp_mask_q[1] &
                     (dp_addr_q == OFF_APP_INT_RST_CTRL);    // RL20

    // Split selector, only written with a correct key
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            split_q <= SPLIT_RESET;
        end else if (ctrl_wr) begin
            split_q <= hwdata[SPLIT_LSB +: 3];                 // RL20
        end
    end

    // Stored words; per byte lane writes, masked reserved bits
    generate
        for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
            localparam logic [11:0] ROFF = OFF_LOW_POWER_CTRL + 12'(4 * r);
            localparam logic [31:0] WM   = REG_WMASK[r*32 +: 32];
            logic hit;                   // This word written now
            // Word match only, so byte and half writes off lane 0 land
            assign hit = dp_valid_q & dp_write_q & (dp_addr_q[11:2] == ROFF[11:2]);
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    regs_q[r] <= REG_RESET[r*32 +: 32];
                end else if (hit) begin
                    // Only lanes in the access change (RL16, RL15, RL21)
                    regs_q[r] <= (regs_q[r] & ~(lane_bits & WM)) |
                                 (hwdata & lane_bits & WM);
                end
            end
        end
    endgenerate

    // Control word reads back key status and the selector
    assign ctrl_rd = {WRITE_KEY_STATUS, 5'h00, split_q, 8'h00};

    // Read decode; unmapped offsets read zero (RL21)
    assign rd_mux =
        (dp_addr_q[11:2] == OFF_APP_INT_RST_CTRL[11:2]) ? ctrl_rd :
        (dp_addr_q[11:2] == OFF_LOW_POWER_CTRL[11:2])   ? regs_q[0] :
        (dp_addr_q[11:2] == OFF_CORE_CONFIG_CTRL[11:2]) ? regs_q[1] :
        (dp_addr_q[11:2] == OFF_FAULT_PRIO_1[11:2])     ? regs_q[2] :     // RL17
        (dp_addr_q[11:2] == OFF_SVC_PRIO_2[11:2])       ? regs_q[3] :     // RL18
        (dp_addr_q[11:2] == OFF_TICK_PRIO_3[11:2])      ? regs_q[4] :     // RL19
                                                          32'h00000000;
    // Read data from flops, gated to the read data phase
    assign hrdata = (dp_valid_q & ~dp_write_q) ? rd_mux : 32'h00000000;

    // Configuration bits steering the core decisions
    assign wake_any    = regs_q[0][WAKE_ANY_BIT];
    assign deep_sel    = regs_q[0][DEEP_SLEEP_BIT];
    assign sleep_exit  = regs_q[0][SLEEP_EXIT_BIT];
    assign align8      = regs_q[1][STACK_ALIGN_BIT];
    assign bf_ign      = regs_q[1][BUS_FAULT_IGN_BIT];
    assign div_trap_en = regs_q[1][DIV_ZERO_TRAP_BIT];
    assign misalign_en = regs_q[1][MISALIGN_TRAP_BIT];
    assign soft_irq_en = regs_q[1][SOFT_IRQ_EN_BIT];
    assign thread_any  = regs_q[1][THREAD_ANY_BIT];

    // Selector values below three behave as three: no sub bits left
    assign split_eff = (split_q < SPLIT_MIN) ? SPLIT_MIN : split_q;
    assign grp_mask  = 4'(4'hf << (split_eff - SPLIT_MIN));   // RL1
    assign new_grp   = core_req.new_prio[7:4] & grp_mask;     // RL1
    assign run_grp   = core_req.run_prio[7:4] & grp_mask;

    // External event pin through two flops before any use
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_event_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end
    assign ext_rise = ext_s2_q & ~ext_s3_q;

    // Disabled interrupts count only with wake-any set (RL3)
    assign wake_ev = core_req.sev_exec | ext_rise |             // RL5
                     core_req.pend_enabled |
                     (wake_any & core_req.pend_disabled);       // RL3

    // Wait-for-event sequencing; a new event beats a consume
    always_comb begin
        ev_state_d = ev_state_q;
        ev_latch_d = ev_latch_q;
        wfe_done_d = 1'b0;
        unique case (ev_state_q)
            EV_RUN: begin
                if (core_req.wfe_exec) begin
                    if (ev_latch_q || wake_ev) begin
                        // Finish at once, keep one event if two (RL4)
                        wfe_done_d = 1'b1;
                        ev_latch_d = ev_latch_q & wake_ev;
                    end else begin
                        ev_state_d = EV_WAIT;
                    end
                end else begin
                    ev_latch_d = ev_latch_q | wake_ev;          // RL4
                end
            end
            EV_WAIT: begin
                if (wake_ev) begin
                    wfe_done_d = 1'b1;                          // RL4
                    ev_state_d = EV_RUN;
                end
            end
        endcase
    end

    // Event state flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ev_state_q <= EV_RUN;
            ev_latch_q <= 1'b0;
        end else begin
            ev_state_q <= ev_state_d;
            ev_latch_q <= ev_latch_d;
        end
    end

    // Core decisions, combined then registered
    always_comb begin
        resp_d                   = '0;
        resp_d.wfe_done          = wfe_done_d;
        resp_d.event_latched     = ev_latch_d;
        resp_d.sleep_enter       = core_req.sleep_req |
                                   (core_req.handler_exit & sleep_exit); // RL7
        resp_d.deep_sleep        = deep_sel;                              // RL6
        resp_d.align_pad         = core_req.exc_entry & align8 &
                                   core_req.sp_bit2;                      // RL8
        resp_d.sp_restore_pad    = core_req.exception_return_code &
                                   core_req.stacked_align;                // RL8
        resp_d.bus_fault_ignored = core_req.ldst_bus_fault &
                                   core_req.neg_prio_exec & bf_ign;       // RL9
        resp_d.lockup            = core_req.ldst_bus_fault &
                                   core_req.neg_prio_exec & ~bf_ign;      // RL9
        resp_d.div_trap          = core_req.div_exec &
                                   core_req.divisor_zero & div_trap_en;   // RL10
        resp_d.div_zero_result   = core_req.div_exec &
                                   core_req.divisor_zero & ~div_trap_en;  // RL10
        resp_d.usage_fault       = core_req.access_exec &
                                   core_req.access_unaligned &
                                   (core_req.access_multi | misalign_en); // RL11 RL12
        resp_d.software_irq_trigger_register_allowed      = core_req.software_irq_trigger_register_access &
                                   (~core_req.unprivileged | soft_irq_en); // RL13
        resp_d.thread_entry_ok   = core_req.return_to_thread &
                                   (~core_req.other_active | thread_any); // RL14
        resp_d.preempt           = new_grp < run_grp;                     // RL2
        resp_d.new_group         = new_grp;
        resp_d.new_sub           = core_req.new_prio[7:4] & ~grp_mask;    // RL1
    end

    // One cycle from request to decision
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            resp_q <= '0;
        end else begin
            resp_q <= resp_d;
        end
    end
    assign core_resp = resp_q;

    // Checks on the block's own state and outputs
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Wait ends the cycle after the waking event
    sequence s_waiting_sev;
        (ev_state_q == EV_WAIT) && core_req.sev_exec;
    endsequence
    sequence s_woken;
        core_resp.wfe_done ##0 (ev_state_q == EV_RUN);
    endsequence

    key_guard_a: assert property ( // RL20
        (dp_valid_q && dp_write_q && dp_addr_q == OFF_APP_INT_RST_CTRL &&
         hwdata[31:16] != WRITE_KEY_VALUE) |=> $stable(split_q))
        else $error("split changed without key");
    prio_low_nibble_a: assert property ( // RL15 RL21
        (((regs_q[2] | regs_q[3] | regs_q[4]) & 32'h0f0f0f0f) == 32'h00000000) &&
        (regs_q[2][31:24] == 8'h00))
        else $error("priority low bits not zero");
    group_only_a: assert property ( // RL2
        (core_req.new_prio[7:4] & grp_mask) == (core_req.run_prio[7:4] & grp_mask)
        |=> !core_resp.preempt)
        else $error("subpriority caused preemption");
    wake_sev_a: assert property ( // RL5
        s_waiting_sev |=> s_woken)
        else $error("send event did not wake");
    latched_wfe_a: assert property ( // RL4
        (ev_state_q == EV_RUN && ev_latch_q && core_req.wfe_exec)
        |=> core_resp.wfe_done && (ev_state_q == EV_RUN))
        else $error("latched event ignored");
    disabled_irq_a: assert property ( // RL3
        (ev_state_q == EV_WAIT && !wake_any && core_req.pend_disabled &&
         !core_req.pend_enabled && !core_req.sev_exec && !ext_rise)
        |=> !core_resp.wfe_done)
        else $error("disabled interrupt woke core");
    sleep_exit_a: assert property ( // RL7
        (core_req.handler_exit && !core_req.sleep_req) |=>
        (core_resp.sleep_enter == $past(sleep_exit)))
        else $error("sleep on exit wrong");
    div_trap_a: assert property ( // RL10
        (core_req.div_exec && core_req.divisor_zero) |=>
        (core_resp.div_trap == $past(div_trap_en)) &&
        (core_resp.div_zero_result == !$past(div_trap_en)))
        else $error("divide by zero outcome wrong");
    multi_fault_a: assert property ( // RL12
        (core_req.access_exec && core_req.access_unaligned &&
         core_req.access_multi) |=> core_resp.usage_fault)
        else $error("unaligned multiple not faulted");
    software_irq_trigger_register_gate_a: assert property ( // RL13
        (core_req.software_irq_trigger_register_access && core_req.unprivileged && !soft_irq_en)
        |=> !core_resp.software_irq_trigger_register_allowed)
        else $error("unprivileged trigger access allowed");
    lockup_a: assert property ( // RL9
        (core_req.ldst_bus_fault && core_req.neg_prio_exec && !bf_ign)
        |=> core_resp.lockup && !core_resp.bus_fault_ignored)
        else $error("bus fault did not lock up");
endmodule : scpst_sys_ctrl

// ### testbench/tb.sv
module tb
    import scpst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Readback masks: low power, config, priority 1, 2, 3
    localparam logic [31:0] WM [5] = '{32'h00000016, 32'h0000031b, 32'h00f0f0f0,
                                       32'hf0000000, 32'hf0f00000};
    logic        mclk = 1'b0;   // 50 MHz clock
    logic        rstn = 1'b0;   // Reset, active low
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic        ext_event_pin = 1'b0;  // External event input
    scpst_req_t  core_req = '0;
    logic        c_v = 1'b0;    // Core request valid this cycle
    logic        c_v_d = 1'b0;  // Core answer due this cycle
    logic        rd_ph = 1'b0;  // Read data phase this cycle
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    scpst_resp_t core_resp;
    logic [31:0] rd_q [$];      // Expected read data
    scpst_resp_t cx_q [$];      // Expected answers, masked
    scpst_resp_t cm_q [$];      // Fields of interest
    int          error_cnt = 0;
    int          n_checks = 0;
    int          seed = 10209;

    scpst_sys_ctrl uut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ext_event_pin(ext_event_pin), .core_req(core_req), .core_resp(core_resp));

    // Free running clock
    always #10 mclk = ~mclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // Monitor: oldest note is compared as each result shows up
    always @(posedge mclk) begin
        if (rd_ph) begin
            check(hrdata, rd_q.pop_front());
            check({31'h0, hresp}, 32'h00000000);
        end
        if (c_v_d) begin
            check(32'(core_resp & cm_q.pop_front()), 32'(cx_q.pop_front()));
        end
        rd_ph <= hsel && htrans[1] && hreadyout && !hwrite;
        c_v_d <= c_v;
    end

    // Single AHB-Lite transfer; address phase, then data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [2:0] sz,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, a, 3'h2, 32'h00000000);
    endtask : rd

    // One core request, then an idle cycle so pulses stay single
    task automatic core(input scpst_req_t r, input scpst_resp_t x, input scpst_resp_t m);
        cx_q.push_back(scpst_resp_t'(x & m));
        cm_q.push_back(m);
        core_req <= r;
        c_v <= 1'b1;
        @(posedge mclk);
        core_req <= '0;
        c_v <= 1'b0;
        @(posedge mclk);
    endtask : core

    // Watchdog: far beyond the roughly two hundred cycles needed
    initial begin
        #(20 * 20000);
        error_cnt++;
        close_out();
    end

    initial begin : main
        scpst_req_t  r;
        scpst_resp_t x;
        scpst_resp_t m;
        logic [3:0]  g;
        logic [11:0] a;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        // Reset values and read-only key status
        rd(OFF_APP_INT_RST_CTRL, {WRITE_KEY_STATUS, 16'h0000});
        for (int i = 0; i < 5; i++) begin
            rd(12'(OFF_LOW_POWER_CTRL + 4 * i), 32'h00000000);
        end
        $display("test reset values done");
        // All ones written; only implemented bits stick
        for (int i = 0; i < 5; i++) begin
            a = 12'(OFF_LOW_POWER_CTRL + 4 * i);
            bus(1'b1, a, 3'h2, 32'hffffffff);
            rd(a, WM[i]);
        end
        bus(1'b1, 12'h100, 3'h2, 32'hffffffff);
        rd(12'h100, 32'h00000000);
        // Byte lane 1 cleared alone, other lanes carry junk
        bus(1'b1, OFF_FAULT_PRIO_1 + 12'h001, 3'h0, 32'h5a5a005a);
        rd(OFF_FAULT_PRIO_1, 32'h00f000f0);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 12'(OFF_LOW_POWER_CTRL + 4 * i), 3'h2, 32'h00000000);
        end
        $display("test register access done");
        // Keyless write refused, keyed write lands
        bus(1'b1, OFF_APP_INT_RST_CTRL, 3'h2, 32'h00000500);
        rd(OFF_APP_INT_RST_CTRL, 32'hfa050000);
        bus(1'b1, OFF_APP_INT_RST_CTRL, 3'h2, {WRITE_KEY_VALUE, 16'h0500});
        rd(OFF_APP_INT_RST_CTRL, 32'hfa050500);
        $display("test write key done");
        // Every split setting with random priorities
        m = '0;
        m.new_group = 4'hf;
        m.new_sub = 4'hf;
        m.preempt = 1'b1;
        for (int s = 0; s < 8; s++) begin
            g = (s < 3) ? 4'hf : 4'(4'hf << (s - 3));
            bus(1'b1, OFF_APP_INT_RST_CTRL, 3'h2, {WRITE_KEY_VALUE, 5'h00, 3'(s), 8'h00});
            for (int k = 0; k < 4; k++) begin
                r = '0;
                r.new_prio = 8'($random(seed));
                r.run_prio = 8'($random(seed));
                x = '0;
                x.new_group = r.new_prio[7:4] & g;
                x.new_sub = r.new_prio[7:4] & ~g;
                x.preempt = (r.new_prio[7:4] & g) < (r.run_prio[7:4] & g);
                core(r, x, m);
            end
        end
        $display("test priority split done");
        // Sleep depth and sleep on handler exit, off then on
        m = '0;
        m.sleep_enter = 1'b1;
        m.deep_sleep = 1'b1;
        for (int b = 0; b < 2; b++) begin
            bus(1'b1, OFF_LOW_POWER_CTRL, 3'h2, (b == 1) ? 32'h00000006 : 32'h00000000);
            r = '0;
            r.handler_exit = 1'b1;
            x = '0;
            x.sleep_enter = 1'(b);
            x.deep_sleep = 1'(b);
            core(r, x, m);
        end
        $display("test low power done");
        // Trap and enable bits, all clear then all set
        m = '0;
        m.div_trap = 1'b1;
        m.div_zero_result = 1'b1;
        m.usage_fault = 1'b1;
        m.software_irq_trigger_register_allowed = 1'b1;
        m.thread_entry_ok = 1'b1;
        m.bus_fault_ignored = 1'b1;
        m.lockup = 1'b1;
        m.align_pad = 1'b1;
        m.sp_restore_pad = 1'b1;
        for (int b = 0; b < 2; b++) begin
            bus(1'b1, OFF_CORE_CONFIG_CTRL, 3'h2, (b == 1) ? 32'h0000031b : 32'h00000000);
            r = '0;
            {r.div_exec, r.divisor_zero, r.access_exec, r.access_unaligned} = 4'hf;
            {r.software_irq_trigger_register_access, r.unprivileged, r.return_to_thread, r.other_active} = 4'hf;
            {r.ldst_bus_fault, r.neg_prio_exec, r.exc_entry, r.sp_bit2} = 4'hf;
            {r.exception_return_code, r.stacked_align} = {1'b1, 1'(b)};
            x = '0;
            {x.div_trap, x.usage_fault, x.software_irq_trigger_register_allowed, x.thread_entry_ok} = {4{1'(b)}};
            {x.bus_fault_ignored, x.align_pad, x.sp_restore_pad} = {3{1'(b)}};
            {x.div_zero_result, x.lockup} = {2{1'(1 - b)}};
            core(r, x, m);
            r = '0;
            {r.access_exec, r.access_unaligned, r.access_multi} = 3'h7;
            {r.software_irq_trigger_register_access, r.return_to_thread} = 2'h3;
            x = '0;
            {x.usage_fault, x.software_irq_trigger_register_allowed, x.thread_entry_ok} = 3'h7;
            core(r, x, m);
        end
        $display("test trap enables done");
        // Wait for event: latch, wake sources, wake on any pending
        bus(1'b1, OFF_LOW_POWER_CTRL, 3'h2, 32'h00000000);
        m = '0;
        m.wfe_done = 1'b1;
        m.event_latched = 1'b1;
        x = '0;
        r = '0;
        r.sev_exec = 1'b1;
        x.event_latched = 1'b1;
        core(r, x, m);
        r = '0;
        r.wfe_exec = 1'b1;
        x.wfe_done = 1'b1;
        x.event_latched = 1'b0;
        core(r, x, m);
        x.wfe_done = 1'b0;
        core(r, x, m);
        r = '0;
        r.pend_disabled = 1'b1;
        core(r, x, m);
        r = '0;
        r.pend_enabled = 1'b1;
        x.wfe_done = 1'b1;
        core(r, x, m);
        bus(1'b1, OFF_LOW_POWER_CTRL, 3'h2, 32'h00000010);
        r = '0;
        r.wfe_exec = 1'b1;
        x.wfe_done = 1'b0;
        core(r, x, m);
        r = '0;
        r.pend_disabled = 1'b1;
        x.wfe_done = 1'b1;
        core(r, x, m);
        // Send event while waiting, then the external pin while waiting
        r = '0;
        r.wfe_exec = 1'b1;
        x.wfe_done = 1'b0;
        core(r, x, m);
        r.wfe_exec = 1'b0;
        r.sev_exec = 1'b1;
        x.wfe_done = 1'b1;
        core(r, x, m);
        r = '0;
        r.wfe_exec = 1'b1;
        x.wfe_done = 1'b0;
        core(r, x, m);
        // Pin edge needs the two sync flops before it wakes; the edge flop keeps it one cycle
        ext_event_pin <= 1'b1;
        repeat (2) @(posedge mclk);
        r = '0;
        x.wfe_done = 1'b1;
        core(r, x, m);
        $display("test wait for event done");
        repeat (3) @(posedge mclk);
        close_out();
    end
endmodule : tb
